// *** hdl/sbsr_pkg.sv ***
// Package of constants and types for the security-banked system registers.
package sbsr_pkg;
	// Coprocessor register group numbers (primary register field).
	localparam logic [3:0] SBSR_CRN_FAULT_ADDR = 4'h6;
	localparam logic [3:0] SBSR_CRN_TLB_OP = 4'h8;
	localparam logic [3:0] SBSR_CRN_TLB_LOCK = 4'ha;
	localparam logic [3:0] SBSR_CRN_MISC = 4'hc;
	// Secondary register field values.
	localparam logic [3:0] SBSR_CRM_C0 = 4'h0;
	localparam logic [3:0] SBSR_CRM_C1 = 4'h1;
	// Opcode_2 selections.
	localparam logic [2:0] SBSR_OP2_DATA = 3'h0;
	localparam logic [2:0] SBSR_OP2_WATCH = 3'h1;
	localparam logic [2:0] SBSR_OP2_INSTR = 3'h2;
	localparam logic [2:0] SBSR_OP2_VBASE = 3'h0;
	localparam logic [2:0] SBSR_OP2_MVBASE = 3'h1;
	// Vector base layout.
	localparam int SBSR_VEC_LOW_BITS = 5;
	localparam logic [31:0] SBSR_VBASE_S_RESET = 32'h0000_0000;
	localparam logic [31:0] SBSR_HIGH_VECTORS = 32'hffff_0000;
	localparam logic [31:0] SBSR_NS_RESET = 32'h0000_0000;
	// Pending interrupt status bit positions.
	localparam int SBSR_ISR_ABORT = 8;
	localparam int SBSR_ISR_IRQ = 7;
	localparam int SBSR_ISR_FIQ = 6;
	// Access control bit for non-secure TLB lockdown.
	localparam int SBSR_NONSECURE_ACCESS_CONTROL_TL_BIT = 17;
	// Cache operation scope.
	typedef enum logic [1:0] {SBSR_SCOPE_LINE, SBSR_SCOPE_ALL} sbsr_scope_e;
	// Register access pipeline state.
	typedef enum logic [1:0] {SBSR_IDLE, SBSR_DONE} sbsr_state_e;
endpackage : sbsr_pkg

// *** hdl/sbsr_cache_sec.sv ***
// Security-tag match logic for L1 cache lookups and maintenance.
`timescale 1ns/100ps
`default_nettype none
module sbsr_cache_sec
	import sbsr_pkg::*;
(
	input wire logic ns_state,
	input wire logic page_nonsecure_attribute,
	input wire logic line_security_tag,
	input wire logic maint_valid,
	input wire sbsr_pkg::sbsr_scope_e maint_scope,
	input wire logic maint_by_index,
	input wire logic maint_is_icache_inval,
	input wire logic icache_lock_nonsecure_allow,
	output logic lookup_tag,
	output logic lookup_hit_allowed,
	output logic maint_apply,
	output logic maint_undef
);
	import sbsr_pkg::*;

	// Tag compared like an extra address bit; non-secure world ignores the descriptor.
	assign lookup_tag = ns_state ? 1'b1 : page_nonsecure_attribute;
	assign lookup_hit_allowed = (line_security_tag == lookup_tag);

	// Secure world acts on all lines except by-address ops follow the page attribute.
	wire secure_apply = (maint_scope == SBSR_SCOPE_ALL) || maint_by_index
		|| (line_security_tag == page_nonsecure_attribute);
	// Non-secure world touches only non-secure lines; instruction invalidate-all may reach all.
	wire ns_all_ok = maint_is_icache_inval && icache_lock_nonsecure_allow;
	wire ns_apply = (maint_scope == SBSR_SCOPE_ALL) ? ns_all_ok : line_security_tag;
	assign maint_apply = maint_valid && (ns_state ? ns_apply : secure_apply);
	// Invalidate-all from non-secure without permission is refused as undefined.
	assign maint_undef = maint_valid && ns_state && (maint_scope == SBSR_SCOPE_ALL)
		&& !ns_all_ok;
endmodule : sbsr_cache_sec
`default_nettype wire

// *** hdl/sbsr_regs.sv ***
// Security-banked system-control registers reached by coprocessor moves.
`timescale 1ns/100ps
`default_nettype none
module sbsr_regs
	import sbsr_pkg::*;
(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic cp_valid,
	input wire logic cp_write,
	input wire logic [3:0] cp_crn,
	input wire logic [3:0] cp_crm,
	input wire logic [2:0] cp_op2,
	input wire logic [31:0] cp_wdata,
	input wire logic ns_state,
	input wire logic user_mode,
	input wire logic [31:0] nonsecure_access_control,
	input wire logic abort_to_monitor_bit,
	input wire logic fast_interrupt_input,
	input wire logic normal_interrupt_input,
	input wire logic ext_abort_event,
	input wire logic ext_abort_is_instr,
	input wire logic [31:0] ext_abort_addr,
	input wire logic abort_taken,
	input wire logic fault_valid,
	input wire logic fault_is_instr,
	input wire logic [31:0] fault_addr,
	input wire logic watch_valid,
	input wire logic [31:0] watch_addr,
	input wire logic exc_valid,
	input wire logic exc_to_monitor,
	input wire logic exc_target_ns,
	input wire logic exc_high_vectors,
	input wire logic [4:0] exc_offset,
	input wire logic tlb_entry_security_tag,
	input wire logic tlb_entry_locked_in,
	input wire logic page_nonsecure_attribute,
	input wire logic line_security_tag,
	input wire logic maint_valid,
	input wire sbsr_pkg::sbsr_scope_e maint_scope,
	input wire logic maint_by_index,
	input wire logic maint_is_icache_inval,
	input wire logic icache_lock_nonsecure_allow,
	output logic cp_done,
	output logic [31:0] cp_rdata,
	output logic cp_undef,
	output logic tlb_op_strobe,
	output logic tlb_lock_strobe,
	output logic tlb_inval_entry,
	output logic tlb_entry_locked,
	output logic exc_pc_valid,
	output logic [31:0] exc_pc,
	output logic lookup_tag,
	output logic lookup_hit,
	output logic maint_apply,
	output logic maint_undef
);
	import sbsr_pkg::*;

	localparam int VB = 32 - SBSR_VEC_LOW_BITS;
	localparam logic [SBSR_VEC_LOW_BITS-1:0] LOW_ZERO = '0;

	logic [31:0] data_fault_address_s_r, data_fault_address_ns_r, instr_fault_address_s_r, instr_fault_address_ns_r, watchpoint_fault_address_r;
	logic [VB-1:0] vbase_s_r, vbase_ns_r, mvbase_r;
	logic abort_pend_r;
	sbsr_state_e state_r;

	// Access decode: each register's select and its permission check.
	wire sel_fa = cp_valid && (cp_crn == SBSR_CRN_FAULT_ADDR);
	wire sel_data_fault_address = sel_fa && (cp_op2 == SBSR_OP2_DATA);
	wire sel_instr_fault_address = sel_fa && (cp_op2 == SBSR_OP2_INSTR);
	wire sel_watchpoint_fault_address = sel_fa && (cp_op2 == SBSR_OP2_WATCH);
	wire sel_tlbop = cp_valid && (cp_crn == SBSR_CRN_TLB_OP);
	wire sel_lock = cp_valid && (cp_crn == SBSR_CRN_TLB_LOCK);
	wire sel_misc = cp_valid && (cp_crn == SBSR_CRN_MISC);
	wire sel_vb = sel_misc && (cp_crm == SBSR_CRM_C0) && (cp_op2 == SBSR_OP2_VBASE);
	wire sel_mvb = sel_misc && (cp_crm == SBSR_CRM_C0) && (cp_op2 == SBSR_OP2_MVBASE);
	wire sel_isr = sel_misc && (cp_crm == SBSR_CRM_C1);
	wire lock_ok = !ns_state || nonsecure_access_control[SBSR_NONSECURE_ACCESS_CONTROL_TL_BIT];

	// Undefined cases: privilege, world and write-only checks.
	wire undef_now = (sel_watchpoint_fault_address && ns_state)
		|| (sel_tlbop && !cp_write)
		|| (sel_lock && !lock_ok)
		|| (sel_vb && user_mode)
		|| (sel_mvb && (user_mode || ns_state));
	wire wr_ok = cp_valid && cp_write && !undef_now;

	// Pending status assembled at the same bit places as the program status.
	logic [31:0] isr_val;
	always_comb
	begin
		isr_val = '0;
		isr_val[SBSR_ISR_ABORT] = abort_pend_r;
		isr_val[SBSR_ISR_IRQ] = normal_interrupt_input;
		isr_val[SBSR_ISR_FIQ] = fast_interrupt_input;
	end

	// Read multiplexer follows the current world for banked copies.
	logic [31:0] rd_mux;
	always_comb
	begin
		rd_mux = '0;
		if (sel_data_fault_address)
			rd_mux = ns_state ? data_fault_address_ns_r : data_fault_address_s_r;
		else if (sel_instr_fault_address)
			rd_mux = ns_state ? instr_fault_address_ns_r : instr_fault_address_s_r;
		else if (sel_watchpoint_fault_address)
			rd_mux = watchpoint_fault_address_r;
		else if (sel_vb)
			rd_mux = {ns_state ? vbase_ns_r : vbase_s_r, LOW_ZERO};
		else if (sel_mvb)
			rd_mux = {mvbase_r, LOW_ZERO};
		else if (sel_isr)
			rd_mux = isr_val;
	end

	// Exception target: monitor base first, then high vectors, else the target world's base.
	wire [31:0] base_sel = exc_to_monitor ? {mvbase_r, LOW_ZERO}
		: exc_high_vectors ? SBSR_HIGH_VECTORS
		: {exc_target_ns ? vbase_ns_r : vbase_s_r, LOW_ZERO};
	wire [31:0] exc_pc_nxt = base_sel | {27'h000_0000, exc_offset};

	// Abort capture into the secure copy when aborts are routed to monitor.
	wire ea_sec = ext_abort_event && abort_to_monitor_bit;

	// Coprocessor answer registers; one cycle after the request.
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			cp_done <= 1'b0;
			cp_rdata <= '0;
			cp_undef <= 1'b0;
			tlb_op_strobe <= 1'b0;
			tlb_lock_strobe <= 1'b0;
			state_r <= SBSR_IDLE;
		end
		else
		begin
			cp_done <= cp_valid;
			cp_undef <= cp_valid && undef_now;
			cp_rdata <= (cp_valid && !cp_write && !undef_now) ? rd_mux : '0;
			tlb_op_strobe <= wr_ok && sel_tlbop;
			tlb_lock_strobe <= wr_ok && sel_lock;
			state_r <= cp_valid ? SBSR_DONE : SBSR_IDLE;
		end
	end

	// TLB invalidate qualification: only entries of the current world.
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
			tlb_inval_entry <= 1'b0;
		else
			tlb_inval_entry <= wr_ok && sel_tlbop
				&& (tlb_entry_security_tag == ns_state);
	end

	// Lock state is not dropped by later restriction; it follows tlb_entry_locked_in and reset clears it.
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
			tlb_entry_locked <= 1'b0;
		else
			tlb_entry_locked <= tlb_entry_locked_in;
	end

	// Fault address banks; hardware capture wins over a same-cycle write.
	always_ff @(posedge sys_clk)
	begin
		if (ea_sec && !ext_abort_is_instr)
			data_fault_address_s_r <= ext_abort_addr;
		else if (fault_valid && !fault_is_instr && !ns_state)
			data_fault_address_s_r <= fault_addr;
		else if (wr_ok && sel_data_fault_address && !ns_state)
			data_fault_address_s_r <= cp_wdata;
		if (ea_sec && ext_abort_is_instr)
			instr_fault_address_s_r <= ext_abort_addr;
		else if (fault_valid && fault_is_instr && !ns_state)
			instr_fault_address_s_r <= fault_addr;
		else if (wr_ok && sel_instr_fault_address && !ns_state)
			instr_fault_address_s_r <= cp_wdata;
	end

	// Non-secure fault copies and the watchpoint register.
	always_ff @(posedge sys_clk)
	begin
		if (fault_valid && !fault_is_instr && ns_state && !ea_sec)
			data_fault_address_ns_r <= fault_addr;
		else if (wr_ok && sel_data_fault_address && ns_state)
			data_fault_address_ns_r <= cp_wdata;
		if (fault_valid && fault_is_instr && ns_state && !ea_sec)
			instr_fault_address_ns_r <= fault_addr;
		else if (wr_ok && sel_instr_fault_address && ns_state)
			instr_fault_address_ns_r <= cp_wdata;
		if (watch_valid)
			watchpoint_fault_address_r <= watch_addr;
		else if (wr_ok && sel_watchpoint_fault_address)
			watchpoint_fault_address_r <= cp_wdata;
	end

	// Vector bases; only the secure copy has a reset value.
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
			vbase_s_r <= SBSR_VBASE_S_RESET[31:SBSR_VEC_LOW_BITS];
		else if (wr_ok && sel_vb && !ns_state)
			vbase_s_r <= cp_wdata[31:SBSR_VEC_LOW_BITS];
	end

	// The non-secure and monitor bases keep no reset; boot code programs them.
	always_ff @(posedge sys_clk)
	begin
		if (wr_ok && sel_vb && ns_state)
			vbase_ns_r <= cp_wdata[31:SBSR_VEC_LOW_BITS];
		if (wr_ok && sel_mvb)
			mvbase_r <= cp_wdata[31:SBSR_VEC_LOW_BITS];
	end

	// Abort pending: a new abort wins over the take in the same cycle.
	// Writes to the status register never reach this flop.
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
			abort_pend_r <= 1'b0;
		else if (ext_abort_event)
			abort_pend_r <= 1'b1;
		else if (abort_taken)
			abort_pend_r <= 1'b0;
	end

	// Exception target address registered for the fetch stage.
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			exc_pc_valid <= 1'b0;
			exc_pc <= SBSR_NS_RESET;
		end
		else
		begin
			exc_pc_valid <= exc_valid;
			exc_pc <= exc_valid ? exc_pc_nxt : exc_pc;
		end
	end

	// Cache security logic lives in its own module; its outputs are registered here.
	logic lk_tag, lk_hit, mt_apply, mt_undef;
	sbsr_cache_sec u_cache_sec (
		.ns_state(ns_state),
		.page_nonsecure_attribute(page_nonsecure_attribute),
		.line_security_tag(line_security_tag),
		.maint_valid(maint_valid),
		.maint_scope(maint_scope),
		.maint_by_index(maint_by_index),
		.maint_is_icache_inval(maint_is_icache_inval),
		.icache_lock_nonsecure_allow(icache_lock_nonsecure_allow),
		.lookup_tag(lk_tag),
		.lookup_hit_allowed(lk_hit),
		.maint_apply(mt_apply),
		.maint_undef(mt_undef)
	);

	// Registered cache qualifiers.
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			lookup_tag <= 1'b0;
			lookup_hit <= 1'b0;
			maint_apply <= 1'b0;
			maint_undef <= 1'b0;
		end
		else
		begin
			lookup_tag <= lk_tag;
			lookup_hit <= lk_hit;
			maint_apply <= mt_apply;
			maint_undef <= mt_undef;
		end
	end

	// Checks on the registered behaviour.
	a_user_vbase_undef: assert property (@(posedge sys_clk) disable iff (!resetn)
		(sel_vb && user_mode) |=> cp_undef && cp_done)
		else $error("User access to vector base not refused");
	a_ns_mvbase_undef: assert property (@(posedge sys_clk) disable iff (!resetn)
		(sel_mvb && ns_state) |=> cp_undef)
		else $error("Non-secure monitor base access not refused");
	a_lock_gate: assert property (@(posedge sys_clk) disable iff (!resetn)
		(sel_lock && ns_state && !nonsecure_access_control[SBSR_NONSECURE_ACCESS_CONTROL_TL_BIT]) |=>
		cp_undef && !tlb_lock_strobe)
		else $error("Non-secure lockdown access not refused");
	a_tlb_no_read: assert property (@(posedge sys_clk) disable iff (!resetn)
		(sel_tlbop && !cp_write) |=> cp_undef && (cp_rdata == 32'h0000_0000))
		else $error("TLB operation read not refused");
	a_abort_sticky: assert property (@(posedge sys_clk) disable iff (!resetn)
		ext_abort_event |=> abort_pend_r)
		else $error("Abort pending not set");
	a_abort_clear: assert property (@(posedge sys_clk) disable iff (!resetn)
		(abort_taken && !ext_abort_event) |=> !abort_pend_r)
		else $error("Abort pending not cleared on take");
	a_isr_layout: assert property (@(posedge sys_clk) disable iff (!resetn)
		(sel_isr && !cp_write) |=> (cp_rdata[31:9] == 23'h0) && (cp_rdata[5:0] == 6'h0)
		&& (cp_rdata[SBSR_ISR_IRQ] == $past(normal_interrupt_input)))
		else $error("Status register layout wrong");
	a_high_vec: assert property (@(posedge sys_clk) disable iff (!resetn)
		(exc_valid && exc_high_vectors && !exc_to_monitor) |=>
		exc_pc_valid && (exc_pc[31:5] == SBSR_HIGH_VECTORS[31:5]))
		else $error("High vector base not used");
	a_ns_lookup: assert property (@(posedge sys_clk) disable iff (!resetn)
		ns_state |=> lookup_tag)
		else $error("Non-secure lookup not on non-secure lines");
	a_tlb_inval_tag: assert property (@(posedge sys_clk) disable iff (!resetn)
		(sel_tlbop && cp_write && (tlb_entry_security_tag != ns_state)) |=> !tlb_inval_entry)
		else $error("Invalidate touched other world entry");
	c_vb_write: cover property (@(posedge sys_clk) disable iff (!resetn) wr_ok && sel_vb);
	c_mvb_read: cover property (@(posedge sys_clk) disable iff (!resetn)
		sel_mvb && !cp_write && !undef_now);
	c_ea_capture: cover property (@(posedge sys_clk) disable iff (!resetn) ea_sec);
	c_monitor_exc: cover property (@(posedge sys_clk) disable iff (!resetn)
		exc_valid && exc_to_monitor);
	c_back_to_back: cover property (@(posedge sys_clk) disable iff (!resetn)
		(state_r == SBSR_DONE) && cp_valid);
endmodule : sbsr_regs
`default_nettype wire

// *** verification/sbsr_core_model.sv ***
// Core pipeline model that issues coprocessor moves to the register bank.
`timescale 1ns/100ps
`default_nettype none
module sbsr_core_model
(
	input wire logic sys_clk,
	input wire logic cp_done,
	input wire logic [31:0] cp_rdata,
	input wire logic cp_undef,
	output logic cp_valid,
	output logic cp_write,
	output logic [3:0] cp_crn,
	output logic [3:0] cp_crm,
	output logic [2:0] cp_op2,
	output logic [31:0] cp_wdata
);
	// The pipeline is quiet until the bench asks for a move.
	initial
	begin
		cp_valid = 1'b0;
		cp_write = 1'b0;
		cp_crn = 4'h0;
		cp_crm = 4'h0;
		cp_op2 = 3'h0;
		cp_wdata = 32'h0000_0000;
	end
	// One move: a pulse on valid, then a bounded wait for the one-cycle answer.
	// Data lines are scrambled afterwards so a stale value is never mistaken for a good one.
	task automatic move(input logic wr, input logic [3:0] crn, input logic [3:0] crm,
		input logic [2:0] op2, input logic [31:0] wd, input int gap,
		output logic [31:0] rd, output logic und, output logic ok);
		int n;
		repeat (gap) @(posedge sys_clk);
		@(posedge sys_clk);
		#1;
		cp_valid = 1'b1;
		cp_write = wr;
		cp_crn = crn;
		cp_crm = crm;
		cp_op2 = op2;
		cp_wdata = wd;
		@(posedge sys_clk);
		#1;
		cp_valid = 1'b0;
		cp_wdata = ~wd;
		n = 0;
		while (cp_done !== 1'b1 && n < 3)
		begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		rd = cp_rdata;
		und = cp_undef;
		ok = cp_done && (n == 0);
	endtask : move
endmodule : sbsr_core_model
`default_nettype wire

// *** verification/sbsr_regs_tb.sv ***
// Self-checking bench for the security-banked system registers.
`timescale 1ns/100ps
`default_nettype none
module sbsr_regs_tb;
	import sbsr_pkg::*;
	logic sys_clk, resetn, cp_valid, cp_write, cp_done, cp_undef, ns_state, user_mode, und, ok;
	logic [3:0] cp_crn, cp_crm;
	logic [2:0] cp_op2;
	logic [4:0] exc_offset;
	logic [31:0] cp_wdata, cp_rdata, nonsecure_access_control, ext_abort_addr, rd;
	logic [31:0] fault_addr, watch_addr, exc_pc;
	logic abort_to_monitor_bit, fast_interrupt_input, normal_interrupt_input, ext_abort_event;
	logic ext_abort_is_instr, abort_taken, fault_valid, fault_is_instr, watch_valid, exc_valid;
	logic exc_to_monitor, exc_target_ns, exc_high_vectors, tlb_entry_security_tag;
	logic tlb_entry_locked_in, page_nonsecure_attribute, line_security_tag, maint_valid;
	logic maint_by_index, maint_is_icache_inval, icache_lock_nonsecure_allow, tlb_op_strobe;
	logic tlb_lock_strobe, tlb_inval_entry, tlb_entry_locked, exc_pc_valid, lookup_tag;
	logic lookup_hit, maint_apply, maint_undef;
	sbsr_scope_e maint_scope;
	int mismatches, num_checks, cycles;
	sbsr_regs dut (.*);
	sbsr_core_model core (.sys_clk(sys_clk), .cp_done(cp_done), .cp_rdata(cp_rdata),
		.cp_undef(cp_undef), .cp_valid(cp_valid), .cp_write(cp_write), .cp_crn(cp_crn),
		.cp_crm(cp_crm), .cp_op2(cp_op2), .cp_wdata(cp_wdata));
	// Clock at 50 MHz.
	initial
	begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	// A hang is cut short at 5000 cycles, well beyond the hundred or so cycles the tests need.
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			mismatches++;
			summarize();
		end
	end
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : summarize
	task automatic tick();
		@(posedge sys_clk);
		#1;
	endtask : tick
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// One move through the core model, judged on done, refusal and read data.
	task automatic mv(input logic wr, input logic [3:0] crn, input logic [3:0] crm,
		input logic [2:0] op2, input logic [31:0] wd, input logic [31:0] exp, input logic xu);
		core.move(wr, crn, crm, op2, wd, 0, rd, und, ok);
		chk("done", 32'h1, {31'h0, ok});
		chk("undef", {31'h0, xu}, {31'h0, und});
		if (!wr || xu)
			chk("rdata", exp, rd);
	endtask : mv
	// The vector base is banked; both bases drop their low five bits and refuse user mode.
	task automatic t_vbase();
		mv(0, SBSR_CRN_MISC, SBSR_CRM_C0, SBSR_OP2_VBASE, 0, 32'h0000_0000, 0);
		mv(1, SBSR_CRN_MISC, SBSR_CRM_C0, SBSR_OP2_VBASE, 32'h1234_567f, 0, 0);
		ns_state = 1'b1;
		mv(1, SBSR_CRN_MISC, SBSR_CRM_C0, SBSR_OP2_VBASE, 32'h8765_43ff, 0, 0);
		mv(0, SBSR_CRN_MISC, SBSR_CRM_C0, SBSR_OP2_VBASE, 0, 32'h8765_43e0, 0);
		ns_state = 1'b0;
		user_mode = 1'b1;
		mv(1, SBSR_CRN_MISC, SBSR_CRM_C0, SBSR_OP2_VBASE, 32'hffff_ffff, 0, 1);
		user_mode = 1'b0;
		mv(0, SBSR_CRN_MISC, SBSR_CRM_C0, SBSR_OP2_VBASE, 0, 32'h1234_5660, 0);
		mv(1, SBSR_CRN_MISC, SBSR_CRM_C0, SBSR_OP2_MVBASE, 32'habcd_ef1f, 0, 0);
		mv(0, SBSR_CRN_MISC, SBSR_CRM_C0, SBSR_OP2_MVBASE, 0, 32'habcd_ef00, 0);
		ns_state = 1'b1;
		mv(0, SBSR_CRN_MISC, SBSR_CRM_C0, SBSR_OP2_MVBASE, 0, 0, 1);
		ns_state = 1'b0;
		user_mode = 1'b1;
		mv(1, SBSR_CRN_MISC, SBSR_CRM_C0, SBSR_OP2_MVBASE, 32'h0, 0, 1);
		user_mode = 1'b0;
		$display("vector base test done");
	endtask : t_vbase
	// Exception entry: target-world base, fixed high base, or monitor base, plus offset.
	task automatic exc(input logic mon, input logic tns, input logic hv, input logic [4:0] off,
		input logic [31:0] exp);
		tick();
		{exc_valid, exc_to_monitor, exc_target_ns, exc_high_vectors, exc_offset} =
			{1'b1, mon, tns, hv, off};
		tick();
		exc_valid = 1'b0;
		chk("exc_pc_valid", 32'h1, {31'h0, exc_pc_valid});
		chk("exc_pc", exp, exc_pc);
		tick();
		chk("exc_pc_valid drop", 32'h0, {31'h0, exc_pc_valid});
		chk("exc_pc hold", exp, exc_pc);
	endtask : exc
	// Pending status follows the interrupt inputs; abort is held until taken.
	task automatic t_status();
		fast_interrupt_input = 1'b1;
		mv(0, SBSR_CRN_MISC, SBSR_CRM_C1, 3'h0, 0, 32'h0000_0040, 0);
		{fast_interrupt_input, normal_interrupt_input} = 2'b01;
		mv(1, SBSR_CRN_MISC, SBSR_CRM_C1, 3'h0, 32'hffff_ffff, 0, 0);
		mv(0, SBSR_CRN_MISC, SBSR_CRM_C1, 3'h0, 0, 32'h0000_0080, 0);
		{ns_state, abort_to_monitor_bit, ext_abort_event} = 3'b111;
		ext_abort_addr = 32'hdead_0010;
		tick();
		ext_abort_event = 1'b0;
		mv(0, SBSR_CRN_MISC, SBSR_CRM_C1, 3'h0, 0, 32'h0000_0180, 0);
		abort_taken = 1'b1;
		tick();
		{abort_taken, normal_interrupt_input, ns_state} = 3'b000;
		mv(0, SBSR_CRN_MISC, SBSR_CRM_C1, 3'h0, 0, 32'h0000_0000, 0);
		mv(0, SBSR_CRN_FAULT_ADDR, 4'h0, SBSR_OP2_DATA, 0, 32'hdead_0010, 0);
		$display("status test done");
	endtask : t_status
	// Fault addresses land in the copy of the current world; watchpoint is secure only.
	task automatic t_fault();
		{ns_state, fault_valid, fault_is_instr, fault_addr} = {3'b110, 32'h0000_a000};
		tick();
		{ns_state, fault_addr} = {1'b0, 32'h0000_b000};
		tick();
		{fault_is_instr, fault_addr} = {1'b1, 32'h0000_c000};
		tick();
		{fault_valid, watch_valid, watch_addr} = {2'b01, 32'h0000_d000};
		tick();
		watch_valid = 1'b0;
		mv(0, SBSR_CRN_FAULT_ADDR, 4'h0, SBSR_OP2_DATA, 0, 32'h0000_b000, 0);
		mv(0, SBSR_CRN_FAULT_ADDR, 4'h0, SBSR_OP2_INSTR, 0, 32'h0000_c000, 0);
		mv(0, SBSR_CRN_FAULT_ADDR, 4'h0, SBSR_OP2_WATCH, 0, 32'h0000_d000, 0);
		ns_state = 1'b1;
		mv(0, SBSR_CRN_FAULT_ADDR, 4'h0, SBSR_OP2_DATA, 0, 32'h0000_a000, 0);
		mv(0, SBSR_CRN_FAULT_ADDR, 4'h0, SBSR_OP2_WATCH, 0, 0, 1);
		{abort_to_monitor_bit, ext_abort_event, ext_abort_addr} = {2'b01, 32'h0000_f000};
		tick();
		{abort_to_monitor_bit, ext_abort_is_instr, ext_abort_addr} = {2'b11, 32'h0000_e000};
		tick();
		{ext_abort_event, ext_abort_is_instr, abort_taken, ns_state} = 4'b0010;
		tick();
		abort_taken = 1'b0;
		mv(0, SBSR_CRN_FAULT_ADDR, 4'h0, SBSR_OP2_DATA, 0, 32'h0000_b000, 0);
		mv(0, SBSR_CRN_FAULT_ADDR, 4'h0, SBSR_OP2_INSTR, 0, 32'h0000_e000, 0);
		$display("fault address test done");
	endtask : t_fault
	// TLB operations are write only; non-secure lockdown needs the access control bit.
	task automatic t_tlb();
		ns_state = 1'b1;
		mv(0, SBSR_CRN_TLB_OP, 4'h7, 3'h0, 0, 0, 1);
		chk("op strobe on read", 32'h0, {31'h0, tlb_op_strobe});
		mv(1, SBSR_CRN_TLB_LOCK, 4'h0, 3'h0, 32'h1, 0, 1);
		nonsecure_access_control = 32'h0002_0000;
		mv(1, SBSR_CRN_TLB_LOCK, 4'h0, 3'h0, 32'h1, 0, 0);
		chk("lock strobe", 32'h1, {31'h0, tlb_lock_strobe});
		tlb_entry_security_tag = 1'b1;
		mv(1, SBSR_CRN_TLB_OP, 4'h7, 3'h0, 32'h0, 0, 0);
		chk("op strobe", 32'h1, {31'h0, tlb_op_strobe});
		chk("inval same world", 32'h1, {31'h0, tlb_inval_entry});
		tlb_entry_security_tag = 1'b0;
		mv(1, SBSR_CRN_TLB_OP, 4'h7, 3'h0, 32'h0, 0, 0);
		chk("inval other world", 32'h0, {31'h0, tlb_inval_entry});
		{tlb_entry_locked_in, nonsecure_access_control} = {1'b1, 32'h0};
		tick();
		tick();
		chk("entry locked", 32'h1, {31'h0, tlb_entry_locked});
		{ns_state, tlb_entry_locked_in} = 2'b00;
		$display("tlb test done");
	endtask : t_tlb
	// Every mix of world, page attribute and line tag, by-address maintenance alongside.
	task automatic t_cache();
		logic et;
		for (int i = 0; i < 8; i++)
		begin
			{ns_state, page_nonsecure_attribute, line_security_tag} = i[2:0];
			{maint_valid, maint_by_index} = 2'b10;
			maint_scope = SBSR_SCOPE_LINE;
			tick();
			tick();
			et = ns_state | page_nonsecure_attribute;
			chk("lookup tag", {31'h0, et}, {31'h0, lookup_tag});
			chk("lookup hit", {31'h0, et == line_security_tag}, {31'h0, lookup_hit});
			chk("maint apply", {31'h0, et == line_security_tag}, {31'h0, maint_apply});
		end
		{ns_state, page_nonsecure_attribute, maint_by_index} = 3'b001;
		tick();
		tick();
		chk("secure by index", 32'h1, {31'h0, maint_apply});
		{ns_state, maint_by_index, maint_is_icache_inval} = 3'b100;
		maint_scope = SBSR_SCOPE_ALL;
		tick();
		tick();
		chk("ns dcache all", 32'h1, {31'h0, maint_undef});
		{maint_is_icache_inval, icache_lock_nonsecure_allow} = 2'b11;
		tick();
		tick();
		chk("ns icache all", 32'h1, {31'h0, maint_apply});
		{ns_state, line_security_tag, maint_is_icache_inval} = 3'b000;
		tick();
		tick();
		chk("secure all", 32'h1, {31'h0, maint_apply});
		{maint_valid, ns_state} = 2'b00;
		$display("cache test done");
	endtask : t_cache
	// Exception entries of every kind, taken in turn.
	task automatic t_exc();
		exc(0, 0, 0, 5'h08, 32'h1234_5668);
		exc(0, 1, 0, 5'h18, 32'h8765_43f8);
		exc(0, 1, 1, 5'h04, 32'hffff_0004);
		exc(1, 0, 0, 5'h0c, 32'habcd_ef0c);
		$display("exception test done");
	endtask : t_exc
	// A second reset in mid-run brings the programmed secure base back to zero.
	task automatic t_reset();
		resetn = 1'b0;
		tick();
		tick();
		resetn = 1'b1;
		mv(0, SBSR_CRN_MISC, SBSR_CRM_C0, SBSR_OP2_VBASE, 0, 32'h0000_0000, 0);
		$display("reset test done");
	endtask : t_reset
	// Main sequence: reset for two cycles, then each scenario in turn.
	initial
	begin
		{resetn, ns_state, user_mode, abort_to_monitor_bit, fast_interrupt_input} = 5'b0;
		{normal_interrupt_input, ext_abort_event, ext_abort_is_instr, abort_taken} = 4'b0;
		{fault_valid, fault_is_instr, watch_valid, exc_valid, exc_to_monitor} = 5'b0;
		{exc_target_ns, exc_high_vectors, tlb_entry_security_tag, tlb_entry_locked_in} = 4'b0;
		{page_nonsecure_attribute, line_security_tag, maint_valid, maint_by_index} = 4'b0;
		{maint_is_icache_inval, icache_lock_nonsecure_allow} = 2'b0;
		{nonsecure_access_control, ext_abort_addr, fault_addr, watch_addr} = 128'h0;
		exc_offset = 5'h00;
		maint_scope = SBSR_SCOPE_LINE;
		{mismatches, num_checks, cycles} = {32'h0, 32'h0, 32'h0};
		repeat (2) @(posedge sys_clk);
		#1;
		resetn = 1'b1;
		t_vbase();
		t_exc();
		t_status();
		t_fault();
		t_tlb();
		t_cache();
		t_reset();
		summarize();
	end
endmodule : sbsr_regs_tb
`default_nettype wire
